// [verilog/axis_sync_dev.sv]
// Purpose: device end, speed and position synchronisation of two axes
// Assumes: main-axis speed and position supplied by the axis generators each cycle
// Notes:   speed is signed pulses per scan unit; encoder inputs synchronous
`timescale 1ns/1ps
// How it works
// - sub axis follows main start, stop, direction
// - speed sync runs until release, stop or estop command, or over-limit main speed
// - main selector: 0 X, 1 Y, 2 encoder
// - both ratios from 1 to 65535
// - sub speed equals main times sub/main
// - sync with aux code on gives 353
// - bad or same main axis gives 355
// - over-limit main speed: 357, emergency decel
// - encoder main: wait for pulses before moving
// - encoder sync needs sub origin established
// - each encoder pulse counts up or down
// - quadrature: A leading is forward
// - encoder mode: dual, pulse-dir, quadrature x4
// - encoder count wraps between min and max
// - position start needs main origin determined
// - position start: busy, move at trigger
// - stop cancels pending position start
// - trigger position is signed 32 bit
// - step 1..150, main axis X or Y
// - trigger fires when position crossed between scans
// - position start with aux code gives 343
// - position start bad main gives 355
// - aux code cleared by release or estop
module axis_sync_dev
  import axis_sync_pkg::*;
#(
  parameter int SPEED_W = 32
)
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // carrier
  axis_sync_if.dev                       bus,
  // axis feedback, index 0 X, 1 Y
  input  wire logic signed [31:0]        axis_pos [2],
  input  wire logic signed [SPEED_W-1:0] axis_speed [2],
  input  wire logic [1:0]                origin_done,
  input  wire logic [1:0]                aux_code_set,
  input  wire logic [SPEED_W-1:0]        speed_limit,
  // encoder
  input  wire logic                      enc_a,
  input  wire logic                      enc_b,
  input  wire logic [1:0]                enc_mode,
  input  wire logic signed [31:0]        enc_max,
  input  wire logic signed [31:0]        enc_min,
  input  wire logic signed [SPEED_W-1:0] enc_speed,
  // axis outputs
  output logic signed [SPEED_W-1:0]      sub_speed_q [2],
  output logic [1:0]                     estop_decel_q,
  output logic [1:0]                     step_start_q,
  output logic [7:0]                     step_no_q [2],
  output logic [1:0]                     aux_code_q,
  output logic signed [31:0]             enc_count_q
);
`include "axis_sync_defs.svh"
  initial
  begin
    if (SPEED_W < 8 || SPEED_W > 48)
      $error("SPEED_W out of range");
  end
  axis_state_t        st_q [2];
  logic [1:0]         msel_q [2];
  logic [15:0]        mrat_q [2];
  logic [15:0]        srat_q [2];
  logic signed [31:0] tpos_q [2];
  logic signed [31:0] prev_pos_q [2];
  logic               a_q, b_q;
  logic [1:0]         enc_seen_q;
  logic               enc_step, enc_dir;
  logic [15:0]        chk_err;
  logic               ax;
  logic [1:0]         lim_hit;

  function automatic logic signed [SPEED_W-1:0] scale_speed(
    input logic signed [SPEED_W-1:0] v, input logic [15:0] sr, input logic [15:0] mr);
    logic signed [SPEED_W+17:0] p;
    p = (v * $signed({1'b0, sr})) / $signed({1'b0, mr});
    return p[SPEED_W-1:0];
  endfunction : scale_speed

  function automatic logic crossed(
    input logic signed [31:0] a, input logic signed [31:0] b, input logic signed [31:0] t);
    return (a <= t && t <= b) || (b <= t && t <= a);
  endfunction : crossed

  function automatic logic signed [SPEED_W-1:0] abs_v(input logic signed [SPEED_W-1:0] v);
    return v[SPEED_W-1] ? -v : v;
  endfunction : abs_v

  assign ax = bus.cmd_axis;

  // command check
  always_comb
  begin
    chk_err = `ERR_NONE;
    if (bus.cmd == CMD_SPEED_SYNC)
    begin
      if (aux_code_q[ax])
        chk_err = `ERR_SPD_AUX;
      else if (bus.main_sel > `MAIN_SEL_ENC || bus.main_sel == {1'b0, ax})
        chk_err = `ERR_MAIN_SEL;
      else if (bus.main_ratio == 16'h0000 || bus.sub_ratio == 16'h0000)
        chk_err = `ERR_BAD_DATA;
      else if (bus.main_sel == `MAIN_SEL_ENC && !origin_done[ax])
        chk_err = `ERR_NO_ORIGIN;
    end
    else if (bus.cmd == position_sync_start_cmd)
    begin
      if (aux_code_q[ax])
        chk_err = `ERR_POS_AUX;
      else if (bus.main_sel > `MAIN_SEL_Y || bus.main_sel == {1'b0, ax})
        chk_err = `ERR_MAIN_SEL;
      else if (bus.step_no < `STEP_MIN || bus.step_no > `STEP_MAX)
        chk_err = `ERR_BAD_DATA;
      else if (!origin_done[bus.main_sel[0]])
        chk_err = `ERR_NO_ORIGIN;
    end
  end

  // done and error answer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus.done     <= 1'b0;
      bus.err_code <= `ERR_NONE;
    end
    else
    begin
      bus.done <= bus.cmd_valid;
      if (bus.cmd_valid)
        bus.err_code <= chk_err;
      else if (|lim_hit)
        bus.err_code <= `ERR_SPD_LIMIT;
    end
  end

  // aux code flag, set wins over clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      aux_code_q <= 2'h0;
    else
      for (int i = 0; i < 2; i++)
      begin
        if (aux_code_set[i])
          aux_code_q[i] <= 1'b1;
        else if (bus.cmd_valid && ax == i[0] &&
                 (bus.cmd == aux_code_release_cmd || bus.cmd == CMD_ESTOP))
          aux_code_q[i] <= 1'b0;
      end
  end

  // encoder decode
  always_comb
  begin
    enc_step = 1'b0;
    enc_dir  = 1'b0;
    case (enc_mode)
      `ENC_MODE_DUAL:
      begin
        enc_step = (enc_a && !a_q) ^ (enc_b && !b_q);
        enc_dir  = enc_a && !a_q;
      end
      `ENC_MODE_PDIR:
      begin
        enc_step = enc_a && !a_q;
        enc_dir  = !enc_b;
      end
      `ENC_MODE_QUAD:
      begin
        enc_step = (enc_a ^ a_q) ^ (enc_b ^ b_q);
        enc_dir  = (enc_a ^ b_q);
      end
      default:
      begin
        enc_step = 1'b0;
        enc_dir  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      a_q         <= 1'b0;
      b_q         <= 1'b0;
      enc_count_q <= 32'sh0;
    end
    else
    begin
      a_q <= enc_a;
      b_q <= enc_b;
      if (enc_step)
      begin
        if (enc_dir)
          enc_count_q <= (enc_count_q >= enc_max) ? enc_min : enc_count_q + 32'sh1;
        else
          enc_count_q <= (enc_count_q <= enc_min) ? enc_max : enc_count_q - 32'sh1;
      end
    end
  end

  // per-axis sync state
  for (genvar g = 0; g < 2; g++)
  begin : g_axis
    logic hit;
    logic over;
    logic signed [SPEED_W-1:0] msp;
    logic signed [31:0]        mpos;
    always_comb
    begin
      msp  = (msel_q[g] == `MAIN_SEL_ENC) ? enc_speed : axis_speed[msel_q[g][0]];
      mpos = axis_pos[msel_q[g][0]];
      hit  = crossed(prev_pos_q[g], mpos, tpos_q[g]);
      over = (st_q[g] == AX_SPEED_SYNC) && (abs_v(msp) > $signed({1'b0, speed_limit}));
    end
    assign lim_hit[g] = over;
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        st_q[g]          <= AX_IDLE;
        msel_q[g]        <= `MAIN_SEL_X;
        mrat_q[g]        <= 16'h0001;
        srat_q[g]        <= 16'h0001;
        tpos_q[g]        <= 32'sh0;
        prev_pos_q[g]    <= 32'sh0;
        step_no_q[g]     <= 8'h00;
        step_start_q[g]  <= 1'b0;
        sub_speed_q[g]   <= '0;
        estop_decel_q[g] <= 1'b0;
        enc_seen_q[g]    <= 1'b0;
      end
      else
      begin
        step_start_q[g] <= 1'b0;
        prev_pos_q[g]   <= mpos;
        if (bus.cmd_valid && ax == g[0] && chk_err == `ERR_NONE)
        begin
          case (bus.cmd)
            CMD_SPEED_SYNC:
            begin
              st_q[g]          <= AX_SPEED_SYNC;
              msel_q[g]        <= bus.main_sel;
              mrat_q[g]        <= bus.main_ratio;
              srat_q[g]        <= bus.sub_ratio;
              enc_seen_q[g]    <= 1'b0;
              estop_decel_q[g] <= 1'b0;
            end
            CMD_SPEED_RELEASE:
            begin
              if (st_q[g] == AX_SPEED_SYNC)
              begin
                st_q[g]        <= AX_IDLE;
                sub_speed_q[g] <= '0;
              end
            end
            position_sync_start_cmd:
            begin
              st_q[g]      <= AX_POS_WAIT;
              msel_q[g]    <= bus.main_sel;
              tpos_q[g]    <= bus.sync_pos;
              step_no_q[g] <= bus.step_no;
              prev_pos_q[g] <= axis_pos[bus.main_sel[0]];
            end
            CMD_STOP, CMD_ESTOP:
            begin
              st_q[g]        <= AX_IDLE;
              sub_speed_q[g] <= '0;
            end
            default:
            begin
            end
          endcase
        end
        else
        begin
          case (st_q[g])
            AX_SPEED_SYNC:
            begin
              if (over)
              begin
                estop_decel_q[g] <= 1'b1;
                sub_speed_q[g]   <= '0;
                st_q[g]          <= AX_IDLE;
              end
              else if (msel_q[g] == `MAIN_SEL_ENC && !enc_seen_q[g])
              begin
                sub_speed_q[g] <= '0;
                if (enc_step)
                  enc_seen_q[g] <= 1'b1;
              end
              else
                sub_speed_q[g] <= scale_speed(msp, srat_q[g], mrat_q[g]);
            end
            AX_POS_WAIT:
            begin
              if (hit)
              begin
                step_start_q[g] <= 1'b1;
                st_q[g]         <= AX_STEP_RUN;
              end
            end
            default:
            begin
            end
          endcase
        end
      end
    end
  end

  assign bus.busy[0] = st_q[0] != AX_IDLE;
  assign bus.busy[1] = st_q[1] != AX_IDLE;
endmodule : axis_sync_dev

// [verilog/axis_sync_defs.svh]
// Purpose: constants for the two-axis synchronous control block
// Assumes: included by bare name
// Notes:   codes, selectors and ranges
`ifndef AXIS_SYNC_DEFS_SVH
`define AXIS_SYNC_DEFS_SVH
`define MAIN_SEL_X        2'h0
`define MAIN_SEL_Y        2'h1
`define MAIN_SEL_ENC      2'h2
`define ENC_MODE_DUAL     2'h0
`define ENC_MODE_PDIR     2'h1
`define ENC_MODE_QUAD     2'h2
`define ERR_NONE          16'h0000
`define ERR_POS_AUX       16'h0157
`define ERR_SPD_AUX       16'h0161
`define ERR_MAIN_SEL      16'h0163
`define ERR_SPD_LIMIT     16'h0165
`define ERR_NO_ORIGIN     16'h0166
`define ERR_BAD_DATA      16'h0167
`define STEP_MIN          8'h01
`define STEP_MAX          8'h96
`endif

// [verilog/axis_sync_pkg.sv]
// Purpose: shared types for the synchronous control block
// Assumes: nothing
// Notes:   command codes and per-axis state
package axis_sync_pkg;
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_SPEED_SYNC,
    CMD_SPEED_RELEASE,
    position_sync_start_cmd,
    CMD_STOP,
    aux_code_release_cmd,
    CMD_ESTOP
  } cmd_t;
  typedef enum logic [1:0] {
    AX_IDLE,
    AX_SPEED_SYNC,
    AX_POS_WAIT,
    AX_STEP_RUN
  } axis_state_t;
endpackage : axis_sync_pkg

// [verilog/axis_sync_if.sv]
// Purpose: carrier between host command end and device end
// Assumes: one clock, host issues one command per strobe
// Notes:   done pulses one cycle after each strobe
`timescale 1ns/1ps
interface axis_sync_if
  import axis_sync_pkg::*;
  (input wire logic clk);
  logic                cmd_valid;
  cmd_t                cmd;
  logic                cmd_axis;
  logic [1:0]          main_sel;
  logic [15:0]         main_ratio;
  logic [15:0]         sub_ratio;
  logic signed [31:0]  sync_pos;
  logic [7:0]          step_no;
  logic                done;
  logic [15:0]         err_code;
  logic [1:0]          busy;
  modport dev  (input cmd_valid, cmd, cmd_axis, main_sel, main_ratio, sub_ratio, sync_pos,
                step_no, output done, err_code, busy);
  modport host (output cmd_valid, cmd, cmd_axis, main_sel, main_ratio, sub_ratio, sync_pos,
                step_no, input done, err_code, busy);
endinterface : axis_sync_if

// [verilog/axis_sync_host.sv]
// Purpose: host end, forwards user commands onto the carrier
// Assumes: user holds req until ack
// Notes:   refuses commands whose aux data is out of range before sending
`timescale 1ns/1ps
module axis_sync_host
  import axis_sync_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // carrier
  axis_sync_if.host        bus,
  // user side
  input  wire logic        req,
  input  wire cmd_t        req_cmd,
  input  wire logic        req_axis,
  input  wire logic [1:0]  req_main_sel,
  input  wire logic [15:0] req_main_ratio,
  input  wire logic [15:0] req_sub_ratio,
  input  wire logic [31:0] req_sync_pos,
  input  wire logic [7:0]  req_step_no,
  input  wire logic [1:0]  aux_code_on,
  output logic             ack,
  output logic [15:0]      last_err_q,
  output logic             local_refused_q
);
`include "axis_sync_defs.svh"
  logic pend_q;
  logic aux_ok;
  // ratios and step range checked here too
  always_comb
  begin
    aux_ok = 1'b1;
    if (req_cmd == CMD_SPEED_SYNC && (req_main_ratio == 16'h0000 || req_sub_ratio == 16'h0000))
      aux_ok = 1'b0;
    if (req_cmd == position_sync_start_cmd &&
        (req_step_no < `STEP_MIN || req_step_no > `STEP_MAX))
      aux_ok = 1'b0;
    // clear aux code before sync commands
    if ((req_cmd == CMD_SPEED_SYNC || req_cmd == position_sync_start_cmd) &&
        aux_code_on[req_axis])
      aux_ok = 1'b0;
  end
  assign bus.cmd_valid  = req && !pend_q && aux_ok;
  assign bus.cmd        = req_cmd;
  assign bus.cmd_axis   = req_axis;
  assign bus.main_sel   = req_main_sel;
  assign bus.main_ratio = req_main_ratio;
  assign bus.sub_ratio  = req_sub_ratio;
  assign bus.sync_pos   = req_sync_pos;
  assign bus.step_no    = req_step_no;
  assign ack = bus.done || (req && !pend_q && !aux_ok);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pend_q <= 1'b0;
    else if (bus.done)
      pend_q <= 1'b0;
    else if (bus.cmd_valid)
      pend_q <= 1'b1;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      last_err_q      <= `ERR_NONE;
      local_refused_q <= 1'b0;
    end
    else if (bus.done)
    begin
      last_err_q      <= bus.err_code;
      local_refused_q <= 1'b0;
    end
    else if (req && !pend_q && !aux_ok)
      local_refused_q <= 1'b1;
  end
endmodule : axis_sync_host

// [bench/axis_sync_sva.sv]
// Purpose: carrier checks for the axis sync block
// Assumes: one clock, rst asynchronous active high
// Notes:   sees carrier signals only
`timescale 1ns/1ps
`include "axis_sync_defs.svh"
module axis_sync_sva
  import axis_sync_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // carrier
  input wire logic        cmd_valid,
  input wire cmd_t        cmd,
  input wire logic        cmd_axis,
  input wire logic [1:0]  main_sel,
  input wire logic        done,
  input wire logic [15:0] err_code,
  input wire logic [1:0]  busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take;
    $rose(cmd_valid);
  endsequence
  sequence s_bad_sel;
    main_sel == 2'h3 || main_sel == {1'b0, cmd_axis};
  endsequence
  chk_take_answer: assert property (s_take |=> done)
    else $error("no done after command");
  chk_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  chk_strobe_once: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  chk_spd_sel_bad: assert property (s_take ##0 cmd == CMD_SPEED_SYNC ##0 s_bad_sel
    |=> err_code == `ERR_MAIN_SEL) else $error("bad speed main axis not refused");
  chk_pos_sel_bad: assert property (s_take ##0 cmd == position_sync_start_cmd
    ##0 (main_sel[1] || main_sel[0] == cmd_axis) |=> err_code == `ERR_MAIN_SEL)
    else $error("bad position main axis not refused");
  chk_accept_busy: assert property (done && err_code == `ERR_NONE
    && (cmd == CMD_SPEED_SYNC || cmd == position_sync_start_cmd) |-> busy[cmd_axis])
    else $error("accepted axis not busy");
  chk_reject_keep: assert property (done && err_code != `ERR_NONE |-> busy == $past(busy))
    else $error("refused command changed axis state");
  chk_stop_idle: assert property (done && cmd == CMD_STOP |-> !busy[cmd_axis])
    else $error("stop left axis busy");
  chk_release_idle: assert property (done && cmd == CMD_SPEED_RELEASE
    && err_code == `ERR_NONE |-> !busy[cmd_axis]) else $error("release left axis busy");
endmodule : axis_sync_sva

// [bench/tb_axis_speed_position_sync.sv]
// Purpose: self-checking bench for the axis sync block
// Assumes: host and device ends joined by the carrier
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
`include "axis_sync_defs.svh"
module tb_axis_speed_position_sync
  import axis_sync_pkg::*;
();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  cmd_t rcmd = CMD_NONE;
  logic rax = 1'b0;
  logic [1:0] rsel = 2'h0;
  logic [15:0] rmr = 16'h0001;
  logic [15:0] rsr = 16'h0001;
  logic [31:0] rpos = 32'h0;
  logic [7:0] rstep = 8'h01;
  logic ack;
  logic refused;
  logic [15:0] last_err;
  logic [15:0] got_err;
  logic signed [31:0] apos [2];
  logic signed [31:0] aspd [2];
  logic signed [31:0] sspd [2];
  logic [7:0] sno [2];
  logic [1:0] org = 2'h0;
  logic [1:0] aux_set = 2'h0;
  logic [1:0] aux_q;
  logic [1:0] aux_mask = 2'h3;
  logic [1:0] estop;
  logic [1:0] sstart;
  logic [31:0] slim = 32'h0000ffff;
  logic ea = 1'b0;
  logic eb = 1'b0;
  logic [1:0] emode = 2'h0;
  logic signed [31:0] emax = 32'sh3;
  logic signed [31:0] emin = -32'sh2;
  logic signed [31:0] espd = 32'sh0;
  logic signed [31:0] ecnt;
  logic signed [31:0] exp_cnt = 32'sh0;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int starts = 0;

  always #4 clk = ~clk;

  axis_sync_if sif (.clk(clk));
  axis_sync_host axis_sync_host_inst (.clk(clk), .rst(rst), .bus(sif), .req(req), .req_cmd(rcmd),
    .req_axis(rax), .req_main_sel(rsel), .req_main_ratio(rmr), .req_sub_ratio(rsr),
    .req_sync_pos(rpos), .req_step_no(rstep), .aux_code_on(aux_q & aux_mask), .ack(ack),
    .last_err_q(last_err), .local_refused_q(refused));
  axis_sync_dev axis_sync_dev_inst (.clk(clk), .rst(rst), .bus(sif), .axis_pos(apos),
    .axis_speed(aspd), .origin_done(org), .aux_code_set(aux_set), .speed_limit(slim),
    .enc_a(ea), .enc_b(eb), .enc_mode(emode), .enc_max(emax), .enc_min(emin), .enc_speed(espd),
    .sub_speed_q(sspd), .estop_decel_q(estop), .step_start_q(sstart), .step_no_q(sno),
    .aux_code_q(aux_q), .enc_count_q(ecnt));
  axis_sync_sva axis_sync_sva_inst (.clk(clk), .rst(rst), .cmd_valid(sif.cmd_valid),
    .cmd(sif.cmd), .cmd_axis(sif.cmd_axis), .main_sel(sif.main_sel), .done(sif.done),
    .err_code(sif.err_code), .busy(sif.busy));

  task automatic test_done();
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  always @(posedge clk)
  begin
    cyc++;
    if (sstart[1] === 1'b1)
      starts++;
    if (cyc == 5000)
    begin
      fails++;
      test_done();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_err(input logic [15:0] got, input logic [15:0] exp);
    cmp(32'(got), 32'(exp));
  endtask : cmp_err

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask : ticks

  // one command through the host, waits for ack
  task automatic issue(input cmd_t c, input logic ax, input logic [1:0] sel,
                       input logic [15:0] mr = 16'h1, input logic [31:0] pos = 32'h0,
                       input logic [7:0] st = 8'h1);
    req = 1'b1;
    rcmd = c;
    rax = ax;
    rsel = sel;
    rmr = mr;
    rpos = pos;
    rstep = st;
    repeat (20)
    begin
      #1;
      if (ack === 1'b1)
        break;
      @(negedge clk);
    end
    cmp(32'(ack), 32'h1);
    got_err = sif.err_code;
    @(negedge clk);
    req = 1'b0;
    @(negedge clk);
  endtask : issue

  task automatic step(input logic a, input logic b, input int d);
    ea = a;
    eb = b;
    ticks(3);
    if (d > 0)
      exp_cnt = (exp_cnt == emax) ? emin : exp_cnt + 1;
    else if (d < 0)
      exp_cnt = (exp_cnt == emin) ? emax : exp_cnt - 1;
    cmp(ecnt, exp_cnt);
  endtask : step

  task automatic quad_fwd();
    step(1'b1, 1'b0, 1);
    step(1'b1, 1'b1, 1);
    step(1'b0, 1'b1, 1);
    step(1'b0, 1'b0, 1);
  endtask : quad_fwd

  task automatic t_enc();
    step(1'b1, 1'b0, 1);
    step(1'b0, 1'b0, 0);
    step(1'b0, 1'b1, -1);
    step(1'b0, 1'b0, 0);
    emode = `ENC_MODE_PDIR;
    step(1'b1, 1'b0, 1);
    step(1'b0, 1'b0, 0);
    step(1'b0, 1'b1, 0);
    step(1'b1, 1'b1, -1);
    step(1'b0, 1'b1, 0);
    step(1'b0, 1'b0, 0);
    emode = `ENC_MODE_QUAD;
    repeat (3) quad_fwd();
    step(1'b0, 1'b1, -1);
    step(1'b1, 1'b1, -1);
    step(1'b1, 1'b0, -1);
    step(1'b0, 1'b0, -1);
  endtask : t_enc

  task automatic t_aux();
    issue(CMD_SPEED_SYNC, 1'b1, 2'h0, 16'h0);
    cmp(32'(refused), 32'h1);
    aux_set = 2'h2;
    ticks(1);
    aux_set = 2'h0;
    ticks(1);
    cmp(32'(aux_q), 32'h2);
    issue(CMD_SPEED_SYNC, 1'b1, 2'h0);
    cmp(32'(refused), 32'h1);
    aux_mask = 2'h0;
    issue(CMD_SPEED_SYNC, 1'b1, 2'h0);
    cmp_err(last_err, `ERR_SPD_AUX);
    issue(position_sync_start_cmd, 1'b1, 2'h0, 16'h1, 32'd1300, 8'd10);
    cmp_err(last_err, `ERR_POS_AUX);
    aux_mask = 2'h3;
    issue(aux_code_release_cmd, 1'b1, 2'h0);
    cmp(32'(aux_q), 32'h0);
    aux_set = 2'h1;
    ticks(1);
    aux_set = 2'h0;
    issue(CMD_ESTOP, 1'b0, 2'h0);
    cmp(32'(aux_q), 32'h0);
  endtask : t_aux

  task automatic t_sel();
    issue(CMD_SPEED_SYNC, 1'b0, 2'h0);
    cmp_err(got_err, `ERR_MAIN_SEL);
    issue(CMD_SPEED_SYNC, 1'b0, 2'h3);
    cmp_err(got_err, `ERR_MAIN_SEL);
    issue(CMD_SPEED_SYNC, 1'b0, `MAIN_SEL_ENC);
    cmp_err(got_err, `ERR_NO_ORIGIN);
    org = 2'h1;
    espd = 32'sd100;
    issue(CMD_SPEED_SYNC, 1'b0, `MAIN_SEL_ENC);
    cmp_err(got_err, `ERR_NONE);
    ticks(4);
    cmp(sspd[0], 32'h0);
    quad_fwd();
    cmp(sspd[0], 32'd100);
    issue(CMD_SPEED_RELEASE, 1'b0, `MAIN_SEL_ENC);
    cmp(32'(sif.busy), 32'h0);
  endtask : t_sel

  task automatic t_speed();
    aspd[0] = 32'sd100;
    issue(CMD_SPEED_SYNC, 1'b1, `MAIN_SEL_X, 16'h2);
    cmp(32'(sif.busy), 32'h2);
    ticks(4);
    cmp(sspd[1], 32'd50);
    aspd[0] = -32'sd100;
    ticks(4);
    cmp(sspd[1], -32'sd50);
    aspd[0] = 32'sd0;
    ticks(4);
    cmp(sspd[1], 32'h0);
    cmp(32'(sif.busy), 32'h2);
    issue(CMD_SPEED_RELEASE, 1'b1, `MAIN_SEL_X, 16'h2);
    cmp(32'(sif.busy), 32'h0);
  endtask : t_speed

  task automatic t_pos();
    org = 2'h0;
    apos[0] = 32'sd1000;
    issue(position_sync_start_cmd, 1'b1, `MAIN_SEL_X, 16'h1, 32'd1300, 8'd10);
    cmp_err(got_err, `ERR_NO_ORIGIN);
    org = 2'h1;
    issue(position_sync_start_cmd, 1'b0, `MAIN_SEL_X, 16'h1, 32'd1300, 8'd10);
    cmp_err(got_err, `ERR_MAIN_SEL);
    issue(position_sync_start_cmd, 1'b1, `MAIN_SEL_X, 16'h1, 32'd1300, 8'd10);
    cmp(32'(sif.busy), 32'h2);
    ticks(4);
    cmp(32'(starts), 32'h0);
    apos[0] = 32'sd1400;
    ticks(4);
    cmp(32'(starts), 32'h1);
    cmp(32'(sno[1]), 32'd10);
    issue(CMD_STOP, 1'b1, 2'h0);
    apos[0] = 32'sd1000;
    issue(position_sync_start_cmd, 1'b1, `MAIN_SEL_X, 16'h1, 32'd1300, 8'd10);
    issue(CMD_STOP, 1'b1, 2'h0);
    apos[0] = 32'sd1400;
    ticks(4);
    cmp(32'(starts), 32'h1);
  endtask : t_pos

  task automatic t_limit();
    slim = 32'd1000;
    issue(CMD_SPEED_SYNC, 1'b1, `MAIN_SEL_X);
    aspd[0] = 32'sd2000;
    ticks(4);
    cmp(32'(estop), 32'h2);
    cmp(32'(sif.busy), 32'h0);
    cmp_err(sif.err_code, `ERR_SPD_LIMIT);
  endtask : t_limit

  initial
  begin
    apos = '{32'sd0, 32'sd0};
    aspd = '{32'sd0, 32'sd0};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_enc();
    t_aux();
    t_sel();
    t_speed();
    t_pos();
    t_limit();
    test_done();
  end
endmodule : tb_axis_speed_position_sync
